/* shm_pkg.sv */
package shm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TX    = 8'h00; // write one command character
  localparam logic [7:0] OFS_RX    = 8'h04; // read next reply character
  localparam logic [7:0] OFS_STS   = 8'h08; // sticky events, write one to clear
  localparam logic [7:0] OFS_MSK   = 8'h0c; // interrupt mask
  localparam logic [7:0] OFS_POS   = 8'h10; // current position
  localparam logic [7:0] OFS_STATE = 8'h14; // live state bits
  localparam logic [7:0] OFS_VEL   = 8'h18; // beginning and end velocity
  // status bit positions
  localparam int ST_DONE  = 0; // move or homing finished
  localparam int ST_HOME  = 1; // home sensor change stopped homing
  localparam int ST_LIMIT = 2; // limit stop
  localparam int ST_REPLY = 3; // reply ready to read
  localparam int ST_ERR   = 4; // command refused
  localparam int ST_W     = 5;
  localparam logic [ST_W-1:0] MSK_RST = 5'h00;
  // sensor filter timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DB_TIME_NS    = 3000;
  // active level must outlast the time, so one cycle more
  localparam int DB_CYC = (DB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  // ascii codes
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_0  = 8'h30;
  localparam logic [7:0] CH_GT = 8'h3e;
  localparam logic [7:0] CH_PL = 8'h2b;
  localparam logic [7:0] CH_MI = 8'h2d;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_D  = 8'h44;
  localparam logic [7:0] CH_H  = 8'h48;
  localparam logic [7:0] CH_L  = 8'h4c;
  localparam logic [7:0] CH_P  = 8'h50;
  localparam logic [7:0] CH_Y  = 8'h59;
  // command letters
  localparam logic [7:0] CMD_NULL = 8'h4e; // homing or set position
  localparam logic [7:0] CMD_BEG  = 8'h42; // beginning velocity
  localparam logic [7:0] CMD_END  = 8'h45; // end velocity
  localparam logic [7:0] CMD_SLP  = 8'h53; // slope
  localparam logic [7:0] CMD_MOVE = 8'h4d; // absolute move
  localparam logic [7:0] CMD_REL  = 8'h52; // relative move
  localparam logic [7:0] CMD_QRY  = 8'h49; // port_state_query
  localparam logic [7:0] CMD_AUTO = 8'h4b; // auto-run
  localparam logic [7:0] CMD_LEG  = 8'h6f; // legacy_profile_cmd lead letter
  // reset values of the profile
  localparam logic [15:0] BV_RST = 16'h0064;
  localparam logic [15:0] EV_RST = 16'h0bb8;
  localparam logic [15:0] SV_RST = 16'h0003;
endpackage

/* shm_motion.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - query reply: prefix, address, '>', digits
// - home query last digit shows blocked
// - zero homing sets position; flags ignore sensors
// - trailing H disables home input
// - digit one seeks home in sign direction
// - home change halts a homing seek at once
// - limit active low, invertible by option
// - limit accepted only beyond 3 us
// - limit checked before steps away, or checked relative
// - limit aborts move, keeps reached position
// - after limit only moves toward home
// - limit query digit one when inactive
// - separate begin, end, slope commands
// - ramp length (end-begin)/slope steps
// - move goes to absolute position with ramp
// - auto-run store executed at power up
// - legacy command selects old profile, also auto-run
// - home active high, beyond 3 us
module shm_motion #(
  parameter int         POS_W  = 32,    // position width
  parameter int         VEL_W  = 16,    // velocity width
  parameter int         ACC_W  = 24,    // step rate accumulator width
  parameter bit         WIDE   = 1'b0,  // wide counter option, ten reply digits
  parameter logic [7:0] PREFIX = 8'h61, // reply prefix character
  parameter logic [7:0] ADDR   = 8'h30  // board address character
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        home_in,
  input  wire logic        limit_in,
  input  wire logic        autorun_nv,
  input  wire logic        legacy_nv,
  output logic             step_out,
  output logic             dir_out,
  output logic             autorun_out,
  output logic             irq
);
  // reply is prefix, address, marker, then zero-padded digits
  localparam logic [3:0] RLEN = WIDE ? 4'd13 : 4'd8; // reply length
  localparam logic [5:0] DBC  = 6'(shm_pkg::DB_CYC);

  // motion engine states
  typedef enum logic [1:0] {
    SHM_IDLE = 2'b00, // waiting
    SHM_MOVE = 2'b01, // counted move
    SHM_SEEK = 2'b10  // homing seek
  } shm_st_type;

  // every flop of the block lives in this record
  typedef struct packed {
    logic [1:0]       hs, ls, as, gs; // synchronisers, bit 0 first stage
    logic             hst, lst;       // filtered levels
    logic [5:0]       hc, lc;         // filter counters
    logic [1:0]       boot;           // power-up delay count
    logic [7:0]       cmd;            // command letter
    logic             neg;            // minus sign seen
    logic [POS_W-1:0] num;            // decimal argument
    logic [3:0]       dig;            // last digit
    logic             fh, fl, fp, fy; // option letters
    logic [1:0]       leg;            // legacy string progress
    logic             ign_h, ign_l;   // sensors ignored
    logic             linv, legacy, autorun;
    logic [VEL_W-1:0] bv, ev, sv, vel;
    logic [POS_W-1:0] pos, rem, acnt;
    logic [ACC_W-1:0] acc;
    shm_st_type       st;
    logic             dir, hdir, chk, lhit, hprev, step;
    logic [3:0]       ridx;           // reply read index
    logic             rbit;           // reply state digit
    logic [shm_pkg::ST_W-1:0] sts, msk;
    logic [31:0]      rdat;
  } shm_regs_type;

  // registered state and its next value
  shm_regs_type r, n;

  // reply character at position i
  function automatic logic [7:0] rchar(input logic [3:0] i, input logic b);
    if (i == 4'd0) begin
      return PREFIX;
    end else if (i == 4'd1) begin
      return ADDR;
    end else if (i == 4'd2) begin
      return shm_pkg::CH_GT;
    end else if (i == RLEN - 4'd1) begin
      return shm_pkg::CH_0 + {7'h00, b};
    end
    return shm_pkg::CH_0;
  endfunction

  // one filter stage: level follows input only after it persists
  function automatic logic [6:0] dbnc(input logic s, input logic lv, input logic [5:0] c);
    if (s == lv) begin
      return {lv, 6'h00};
    end else if (c == DBC - 6'd1) begin
      return {s, 6'h00};
    end
    return {lv, c + 6'd1};
  endfunction

  // next state
  always_comb begin
    logic        acc_w, away, hact, lact, go, ovf;
    logic [7:0]  ch;
    logic [6:0]  fh7, fl7;
    logic [ACC_W:0] asum;
    logic [VEL_W:0] vs;
    logic [POS_W-1:0] tgt, d;
    acc_w = 1'b0;
    away  = 1'b0;
    go    = 1'b0;
    ovf   = 1'b0;
    hact  = 1'b0;
    lact  = 1'b0;
    fh7   = '0;
    fl7   = '0;
    ch    = pwdata[7:0];
    tgt   = '0;
    d     = '0;
    asum  = '0;
    vs    = '0;
    n = r;
    n.step = 1'b0;
    // synchronise pins, filter sensors
    n.hs = {r.hs[0], home_in};
    n.ls = {r.ls[0], limit_in};
    n.as = {r.as[0], autorun_nv};
    n.gs = {r.gs[0], legacy_nv};
    fh7 = dbnc(r.hs[1], r.hst, r.hc);
    fl7 = dbnc(r.ls[1], r.lst, r.lc);
    n.hst = fh7[6];
    n.hc  = fh7[5:0];
    n.lst = fl7[6];
    n.lc  = fl7[5:0];
    hact = r.hst & ~r.ign_h;
    lact = ~r.lst ^ r.linv;
    // apb: capture read data in setup, act in access
    acc_w = psel & penable & pwrite;
    if (psel & ~penable & ~pwrite) begin
      case (paddr)
        shm_pkg::OFS_RX:    n.rdat = (r.ridx < RLEN) ? {24'h0, rchar(r.ridx, r.rbit)} : '0;
        shm_pkg::OFS_STS:   n.rdat = {27'h0, r.sts};
        shm_pkg::OFS_MSK:   n.rdat = {27'h0, r.msk};
        shm_pkg::OFS_POS:   n.rdat = 32'(r.pos);
        shm_pkg::OFS_STATE: n.rdat = {23'h0, r.ridx < RLEN, r.autorun, r.legacy, r.lhit,
                                      lact, hact, r.dir, r.st};
        shm_pkg::OFS_VEL:   n.rdat = {r.ev, r.bv};
        default:            n.rdat = '0;
      endcase
    end
    // a read of the reply port pops one character
    if (psel & penable & ~pwrite & (paddr == shm_pkg::OFS_RX) & (r.ridx < RLEN)) begin
      n.ridx = r.ridx + 4'd1;
    end
    // write one to clear; event sets further down win
    if (acc_w & (paddr == shm_pkg::OFS_STS)) begin
      n.sts = r.sts & ~pwdata[shm_pkg::ST_W-1:0];
    end
    // mask takes the low bits only
    if (acc_w & (paddr == shm_pkg::OFS_MSK)) begin
      n.msk = pwdata[shm_pkg::ST_W-1:0];
    end
    // power up: run the stored contents once
    // wait until the strap synchronisers have filled
    if (r.boot != 2'h0) begin
      n.boot = r.boot - 2'h1;
    end
    if (r.boot == 2'h1) begin
      n.autorun = r.as[1];
      if (r.as[1] & r.gs[1]) begin
        n.legacy = 1'b1;
      end
    end
    // motion engine
    if (r.st != SHM_IDLE) begin
      asum = {1'b0, r.acc} + {{(ACC_W - VEL_W + 1){1'b0}}, r.vel};
      n.acc = asum[ACC_W-1:0];
      ovf = asum[ACC_W];
      away = (r.st == SHM_MOVE) & (r.dir != r.hdir);
      // home edge ends the seek and zeroes position
      if ((r.st == SHM_SEEK) & (hact != r.hprev)) begin
        n.st = SHM_IDLE;
        n.pos = '0;
        n.sts[shm_pkg::ST_HOME] = 1'b1;
        n.sts[shm_pkg::ST_DONE] = 1'b1;
      end else if (ovf & (away | r.chk) & ~r.ign_l & lact) begin
        n.st = SHM_IDLE;
        n.lhit = 1'b1;
        n.sts[shm_pkg::ST_LIMIT] = 1'b1;
        n.sts[shm_pkg::ST_DONE] = 1'b1;
      end else if (ovf) begin
        // one step: move position and count down
        n.step = 1'b1;
        n.pos = r.dir ? r.pos - POS_W'(1) : r.pos + POS_W'(1);
        n.rem = r.rem - POS_W'(1);
        if (r.legacy) begin
          n.vel = r.vel;
        end else if ((r.st == SHM_MOVE) & (r.rem - POS_W'(1) <= r.acnt) & (r.acnt != '0)) begin
          // decelerate once the remaining steps fit the ramp
          vs = {1'b0, r.vel} - {1'b0, r.sv};
          n.vel = (vs[VEL_W] | (vs[VEL_W-1:0] < r.bv)) ? r.bv : vs[VEL_W-1:0];
          n.acnt = r.acnt - POS_W'(1);
        end else if (r.vel < r.ev) begin
          // accelerate toward the end velocity
          vs = {1'b0, r.vel} + {1'b0, r.sv};
          n.vel = (vs > {1'b0, r.ev}) ? r.ev : vs[VEL_W-1:0];
          n.acnt = r.acnt + POS_W'(1);
        end
        // last step of a counted move
        if ((r.st == SHM_MOVE) & (r.rem == POS_W'(1))) begin
          n.st = SHM_IDLE;
          n.sts[shm_pkg::ST_DONE] = 1'b1;
        end
      end
    end
    // command characters
    if (acc_w & (paddr == shm_pkg::OFS_TX)) begin
      if (ch == shm_pkg::CH_CR) begin
        n.cmd = '0;
        n.neg = 1'b0;
        n.num = '0;
        n.dig = '0;
        {n.fh, n.fl, n.fp, n.fy} = 4'h0;
        n.leg = '0;
        // execute the collected command
        case (r.cmd)
          shm_pkg::CMD_NULL: begin
            if (r.st != SHM_IDLE) begin
              n.sts[shm_pkg::ST_ERR] = 1'b1;
            end else begin
              n.ign_h = r.fh;
              n.ign_l = r.fl;
              n.linv  = r.fp;
              n.lhit  = 1'b0;
              n.hdir  = r.neg;
              if ((r.dig == 4'd1) & ~r.fh) begin
                n.st = SHM_SEEK;
                n.dir = r.neg;
                n.hprev = hact;
                n.chk = 1'b0;
                go = 1'b1;
              end else begin
                n.pos = '0;
              end
            end
          end
          shm_pkg::CMD_BEG:  n.bv = r.num[VEL_W-1:0];
          shm_pkg::CMD_END:  n.ev = r.num[VEL_W-1:0];
          shm_pkg::CMD_SLP:  n.sv = r.num[VEL_W-1:0];
          shm_pkg::CMD_MOVE, shm_pkg::CMD_REL: begin
            if (r.cmd == shm_pkg::CMD_MOVE) begin
              tgt = r.neg ? '0 - r.num : r.num;
            end else begin
              tgt = r.neg ? r.pos - r.num : r.pos + r.num;
            end
            d = tgt - r.pos;
            if ((r.st != SHM_IDLE) | (r.lhit & (d[POS_W-1] != r.hdir) & (d != '0))) begin
              n.sts[shm_pkg::ST_ERR] = 1'b1;
            end else if (d == '0) begin
              n.sts[shm_pkg::ST_DONE] = 1'b1;
            end else begin
              n.st  = SHM_MOVE;
              n.dir = d[POS_W-1];
              n.rem = d[POS_W-1] ? '0 - d : d;
              n.chk = (r.cmd == shm_pkg::CMD_REL) & r.fy;
              n.lhit = r.lhit & (d[POS_W-1] != r.hdir) ? 1'b1 : 1'b0;
              go = 1'b1;
            end
          end
          shm_pkg::CMD_QRY: begin
            n.ridx = '0;
            n.rbit = (r.dig == 4'd1) ? hact : (r.dig == 4'd3) ? ~lact : 1'b0;
            n.sts[shm_pkg::ST_REPLY] = 1'b1;
          end
          shm_pkg::CMD_AUTO: n.autorun = (r.num != '0);
          shm_pkg::CMD_LEG: begin
            if (r.leg == 2'd3) begin
              n.legacy = 1'b1;
            end else begin
              n.sts[shm_pkg::ST_ERR] = 1'b1;
            end
          end
          default: n.sts[shm_pkg::ST_ERR] = 1'b1;
        endcase
        // new motion restarts ramp and accumulator
        if (go) begin
          n.vel  = r.legacy ? r.ev : r.bv;
          n.acc  = '0;
          n.acnt = '0;
        end
      end else if (r.cmd == '0) begin
        n.cmd = ch;
      end else if (ch == shm_pkg::CH_MI) begin
        n.neg = 1'b1;
      end else if ((ch >= shm_pkg::CH_0) & (ch <= shm_pkg::CH_0 + 8'h09)) begin
        // decimal digits accumulate, last one kept
        n.num = (r.num << 3) + (r.num << 1) + POS_W'(ch - shm_pkg::CH_0);
        n.dig = 4'(ch - shm_pkg::CH_0);
      end else begin
        // legacy string progress and option letters
        if ((r.cmd == shm_pkg::CMD_LEG) &
            (((r.leg == 2'd0) & (ch == shm_pkg::CH_AT)) | ((r.leg == 2'd1) & (ch == shm_pkg::CH_L))
             | ((r.leg == 2'd2) & (ch == shm_pkg::CH_D)))) begin
          n.leg = r.leg + 2'd1;
        end
        n.fh = r.fh | (ch == shm_pkg::CH_H);
        n.fl = r.fl | (ch == shm_pkg::CH_L);
        n.fp = r.fp | (ch == shm_pkg::CH_P);
        n.fy = r.fy | (ch == shm_pkg::CH_Y);
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{hs: 2'h0, ls: 2'h0, as: 2'h0, gs: 2'h0, hst: 1'b0, lst: 1'b1, hc: 6'h00,
             lc: 6'h00, boot: 2'h3, cmd: 8'h00, neg: 1'b0, num: '0, dig: 4'h0, fh: 1'b0,
             fl: 1'b0, fp: 1'b0, fy: 1'b0, leg: 2'h0, ign_h: 1'b0, ign_l: 1'b0,
             linv: 1'b0, legacy: 1'b0, autorun: 1'b0, bv: shm_pkg::BV_RST,
             ev: shm_pkg::EV_RST, sv: shm_pkg::SV_RST, vel: '0, pos: '0, rem: '0,
             acnt: '0, acc: '0, st: SHM_IDLE, dir: 1'b0, hdir: 1'b0, chk: 1'b0,
             lhit: 1'b0, hprev: 1'b0, step: 1'b0, ridx: RLEN, rbit: 1'b0,
             sts: 5'h00, msk: shm_pkg::MSK_RST, rdat: 32'h0000_0000};
    end else begin
      r <= n;
    end
  end

  // outputs from the state record, irq masked by msk; pready and pslverr tied off
  assign prdata      = r.rdat;
  assign pready      = 1'b1;
  assign pslverr     = 1'b0;
  assign step_out    = r.step;
  assign dir_out     = r.dir;
  assign autorun_out = r.autorun;
  assign irq         = |(r.sts & r.msk);
endmodule // shm_motion

/* shm_motion_sva.sv */
`timescale 1ns/100ps
// port-level checks of the motion block
module shm_motion_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        step_out,
  input wire logic        autorun_nv,
  input wire logic        autorun_out,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read setup cycle, where read data is captured
  wire rd_set = psel && !penable && !pwrite;
  a_ready_high: assert property (pready) else $error("pready low");
  a_no_slverr: assert property (!pslverr) else $error("pslverr raised");
  a_step_pulse: assert property (step_out |=> !step_out[*3])
    else $error("step pulse too long or too dense");
  a_irq_reset: assert property ($rose(presetn) |-> !irq) else $error("irq after reset");
  a_autorun_strap: assert property ($rose(presetn) |-> ##[1:4] autorun_out == autorun_nv)
    else $error("auto-run strap not taken");
  a_mask_clear: assert property (psel && penable && pwrite && paddr == shm_pkg::OFS_MSK
    && pwdata[4:0] == 5'h00 |=> !irq) else $error("irq with mask cleared");
  a_rdata_hold: assert property (!rd_set |=> $stable(prdata)) else $error("prdata moved");
  a_unmapped_rd: assert property (rd_set && paddr == 8'h40 |=> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // shm_motion_sva

bind shm_motion shm_motion_sva u_sva (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .step_out, .autorun_nv, .autorun_out, .irq
);

/* shm_host.sv */
`timescale 1ns/100ps
// apb master standing in for the terminal host
module shm_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer: setup, then access until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // command string, one char per write, closed by carriage return
  task automatic cmd(input string s);
    logic [31:0] q;
    for (int i = 0; i < s.len(); i++) begin
      xfer(1'b1, shm_pkg::OFS_TX, {24'h0, s[i]}, q);
    end
    xfer(1'b1, shm_pkg::OFS_TX, {24'h0, shm_pkg::CH_CR}, q);
  endtask
endmodule // shm_host

/* tb.sv */
`timescale 1ns/100ps
// bench for the stepper motion block
module tb;
  logic pclk = 1'b0, presetn = 1'b0, home_in = 1'b0, limit_in = 1'b1; // clock, reset, sensors
  logic autorun_nv = 1'b1, legacy_nv = 1'b1; // straps
  logic psel, penable, pwrite, pready, pslverr, step_out, dir_out, autorun_out, irq;
  logic [7:0]  paddr; // bus address
  logic [31:0] pwdata, prdata, q; // bus data, last read
  int fails = 0, check_count = 0, steps = 0, s0; // counters
  always #50 pclk = ~pclk;
  // count motor steps
  always @(posedge pclk) steps <= steps + int'(step_out === 1'b1);
  shm_motion #(.ACC_W(16)) u_shm_motion (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .home_in, .limit_in, .autorun_nv, .legacy_nv,
    .step_out, .dir_out, .autorun_out, .irq);
  shm_host u_shm_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic results;
    if (fails == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    u_shm_host.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_shm_host.xfer(1'b1, a, d, q);
  endtask
  task automatic cmd(input string s);
    u_shm_host.cmd(s);
  endtask
  task automatic rst(input logic ar, input logic lg);
    @(posedge pclk);
    presetn <= 1'b0;
    autorun_nv <= ar;
    legacy_nv <= lg;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // wait for a status event under a bound, then clear all events
  task automatic wdone(input int b);
    int n = 0;
    rd(shm_pkg::OFS_STS);
    while (q[b] !== 1'b1 && n < 500) begin
      rd(shm_pkg::OFS_STS);
      n++;
    end
    chk("event", {31'h0, q[b]}, 32'h1);
    wr(shm_pkg::OFS_STS, 32'h1f);
  endtask
  task automatic reply(input logic [7:0] d);
    string e = "a0>0000";
    for (int i = 0; i < 7; i++) begin
      rd(shm_pkg::OFS_RX);
      chk("reply", q, {24'h0, e[i]});
    end
    rd(shm_pkg::OFS_RX);
    chk("digit", q, {24'h0, d});
  endtask
  task automatic t_power;
    repeat (4) @(posedge pclk);
    chk("autorun", {31'h0, autorun_out}, 32'h1);
    rd(shm_pkg::OFS_STATE);
    chk("legacy", {31'h0, q[6]}, 32'h1);
    rd(shm_pkg::OFS_VEL);
    chk("vel", q, {shm_pkg::EV_RST, shm_pkg::BV_RST});
    rd(8'h40);
    chk("unmapped", q, 32'h0);
  endtask
  task automatic t_query;
    wr(shm_pkg::OFS_MSK, 32'h8);
    cmd("I1");
    @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    reply(8'h30);
    wr(shm_pkg::OFS_STS, 32'h8);
    @(posedge pclk);
    chk("irq clr", {31'h0, irq}, 32'h0);
    home_in <= 1'b1;
    repeat (40) @(posedge pclk);
    cmd("I1");
    reply(8'h31);
    home_in <= 1'b0;
    cmd("I3");
    reply(8'h31);
    limit_in <= 1'b0;
    repeat (40) @(posedge pclk);
    cmd("I3");
    reply(8'h30);
    limit_in <= 1'b1;
    wr(shm_pkg::OFS_MSK, 32'h0);
  endtask
  task automatic t_move;
    cmd("B2000");
    cmd("E8000");
    cmd("S1000");
    rd(shm_pkg::OFS_VEL);
    chk("profile", q, 32'h1f4007d0);
    cmd("N+0");
    rd(shm_pkg::OFS_POS);
    chk("setpos", q, 32'h0);
    s0 = steps;
    wr(shm_pkg::OFS_TX, 32'h4d);
    wr(shm_pkg::OFS_TX, 32'h32);
    wr(shm_pkg::OFS_TX, 32'h30);
    repeat (50) @(posedge pclk);
    chk("no cr", steps - s0, 32'h0);
    wr(shm_pkg::OFS_TX, 32'h0d);
    wdone(shm_pkg::ST_DONE);
    rd(shm_pkg::OFS_POS);
    chk("pos", q, 32'd20);
    chk("steps", steps - s0, 32'd20);
  endtask
  task automatic t_home;
    s0 = steps;
    cmd("N-1");
    repeat (100) @(posedge pclk);
    chk("dir", {31'h0, dir_out}, 32'h1);
    chk("seeking", {31'h0, steps > s0}, 32'h1);
    home_in <= 1'b1;
    repeat (10) @(posedge pclk);
    home_in <= 1'b0;
    repeat (60) @(posedge pclk);
    rd(shm_pkg::OFS_STATE);
    chk("glitch", {30'h0, q[1:0]}, 32'h2);
    home_in <= 1'b1;
    wdone(shm_pkg::ST_HOME);
    s0 = steps;
    repeat (100) @(posedge pclk);
    chk("halt", steps - s0, 32'h0);
    home_in <= 1'b0;
  endtask
  task automatic t_limit;
    s0 = steps;
    cmd("R+40Y");
    repeat (60) @(posedge pclk);
    limit_in <= 1'b0;
    repeat (10) @(posedge pclk);
    limit_in <= 1'b1;
    repeat (60) @(posedge pclk);
    rd(shm_pkg::OFS_STATE);
    chk("short limit", {30'h0, q[1:0]}, 32'h1);
    limit_in <= 1'b0;
    wdone(shm_pkg::ST_LIMIT);
    rd(shm_pkg::OFS_POS);
    chk("limit pos", q, steps - s0);
    cmd("R+5");
    rd(shm_pkg::OFS_STS);
    chk("away refused", {31'h0, q[shm_pkg::ST_ERR]}, 32'h1);
    wr(shm_pkg::OFS_STS, 32'h1f);
    s0 = steps;
    cmd("R-3");
    wdone(shm_pkg::ST_DONE);
    chk("back", steps - s0, 32'd3);
    limit_in <= 1'b1;
  endtask
  task automatic t_modes;
    cmd("K1");
    @(posedge pclk);
    chk("auto set", {31'h0, autorun_out}, 32'h1);
    cmd("o@LD");
    rd(shm_pkg::OFS_STATE);
    chk("legacy cmd", {31'h0, q[6]}, 32'h1);
  endtask
  // option letters: home disabled, limit ignored and inverted
  task automatic t_flags;
    cmd("N+0HLP");
    home_in <= 1'b1;
    repeat (40) @(posedge pclk);
    cmd("I1");
    reply(8'h30);
    cmd("I3");
    reply(8'h30);
    s0 = steps;
    cmd("R+2Y");
    wdone(shm_pkg::ST_DONE);
    chk("ignored limit", steps - s0, 32'd2);
    home_in <= 1'b0;
  endtask
  // watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    results;
  end
  initial begin
    rst(1'b1, 1'b1);
    t_power;
    rst(1'b0, 1'b0);
    t_query;
    t_move;
    t_home;
    t_limit;
    t_modes;
    t_flags;
    results;
  end
endmodule // tb
